// ==== logic/tec_consts.svh ====
// Offsets, field positions and reset values of the timer/event counter block.
// Assumes a byte-wide special function register port with a 4-bit address.
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH

`define TEC_ADDR_CNT_A      4'h0
`define TEC_ADDR_CTRL_A     4'h1
`define TEC_ADDR_WIDE_LOW   4'h2
`define TEC_ADDR_WIDE_HIGH  4'h3
`define TEC_ADDR_CTRL_WIDE  4'h4
`define TEC_ADDR_CNT_C      4'h5
`define TEC_ADDR_CTRL_C     4'h6
`define TEC_ADDR_CNT_D      4'h7
`define TEC_ADDR_CTRL_D     4'h8

`define TEC_MODE_HI         7
`define TEC_MODE_LO         6
`define TEC_CLK_SEL_BIT     5
`define TEC_RUN_BIT         4
`define TEC_EDGE_BIT        3
`define TEC_PSC_HI          2

`define TEC_CTRL_RESET      8'h00
`define TEC_CTRL_MASK_NARROW 8'hdf
`define TEC_CTRL_MASK_WIDE  8'hf8
`define TEC_PRELOAD_RESET   16'h0000

`define TEC_PSC_W           7
`define TEC_WIDE_DIV_MASK   7'h03

`endif

// ==== logic/tec_pkg.sv ====
// Types shared by the timer/event counter block.
// Assumes tec_consts.svh is available on the include path.
package tec_pkg;

    // Operating mode, in the order of the two mode select bits 00..11.
    typedef enum logic [1:0] {
        TEC_IDLE,
        TEC_EVENT,
        TEC_TIMER,
        TEC_PWM
    } tec_mode_e;

endpackage

// ==== logic/tec_counter.sv ====
// One count-up timer/event counter channel with preload and overflow reload.
// Assumes the pin input is synchronous to clk_i and tick_i is a one-cycle enable.
module tec_counter #(
    parameter int W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  tec_pkg::tec_mode_e     mode_i,
    input  wire logic              run_i,
    input  wire logic              edge_sel_i,
    input  wire logic              tick_i,
    input  wire logic              pdown_i,
    input  wire logic              pin_i,
    input  wire logic              load_i,
    input  wire logic [W-1:0]      load_data_i,
    output logic      [W-1:0]      count_o,
    output logic                   ovf_o,
    output logic                   run_clr_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] pre;
        logic         pin;
        logic         meas;
        logic         ovf;
    } tec_cnt_state_s;

    tec_cnt_state_s q;
    tec_cnt_state_s d;
    logic           inc;
    logic           rise;
    logic           fall;
    logic           sel_edge;
    logic           act_edge;
    logic           ret_edge;

    always_comb begin
        d         = q;
        inc       = 1'b0;
        run_clr_o = 1'b0;
        rise      = pin_i & ~q.pin;
        fall      = ~pin_i & q.pin;
        // Edge select low counts rising edges; a pulse measure then starts on a fall.
        sel_edge  = edge_sel_i ? fall : rise;
        act_edge  = edge_sel_i ? rise : fall;
        ret_edge  = edge_sel_i ? fall : rise;
        d.pin     = pin_i;
        d.ovf     = 1'b0;
        case (mode_i)
            tec_pkg::TEC_TIMER: begin
                d.meas = 1'b0;
                inc    = run_i & tick_i & ~pdown_i;
            end
            tec_pkg::TEC_EVENT: begin
                d.meas = 1'b0;
                // Pin edges count even in power-down; the prescaler is bypassed.
                inc    = run_i & sel_edge;
            end
            tec_pkg::TEC_PWM: begin
                if (!run_i) begin
                    d.meas = 1'b0;
                end else if (!q.meas) begin
                    d.meas = act_edge;
                end else if (ret_edge) begin
                    d.meas    = 1'b0;
                    run_clr_o = 1'b1;
                end else begin
                    inc = tick_i & ~pdown_i;
                end
            end
            default: begin
                d.meas = 1'b0;
            end
        endcase
        if (inc) begin
            if (&q.cnt) begin
                d.cnt = q.pre;
                d.ovf = 1'b1;
            end else begin
                d.cnt = q.cnt + W'(1);
            end
        end
        if (load_i) begin
            d.pre = load_data_i;
            if (!run_i) begin
                d.cnt = load_data_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count_o = q.cnt;
    assign ovf_o   = q.ovf;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_measuring;
        q.meas && run_i && mode_i == tec_pkg::TEC_PWM;
    endsequence

    sequence s_pulse_end;
        ret_edge ##1 !q.meas;
    endsequence

    a_inc_by_one: assert property (inc && !(&q.cnt) && !load_i |=> q.cnt == $past(q.cnt) + W'(1))
        else $error("count did not step by one");
    a_ovf_reload: assert property (inc && (&q.cnt) && !load_i |=> ovf_o && q.cnt == $past(q.pre))
        else $error("overflow did not reload and flag");
    a_off_load: assert property (load_i && !run_i |=> q.cnt == $past(load_data_i))
        else $error("preload write while off not copied to count");
    a_on_load_keep: assert property (load_i && run_i && !inc |=> q.cnt == $past(q.cnt) && q.pre == $past(load_data_i))
        else $error("preload write while running disturbed count");
    a_event_hold: assert property (mode_i == tec_pkg::TEC_EVENT && !sel_edge && !load_i |=> q.cnt == $past(q.cnt))
        else $error("event count moved without a pin edge");
    a_pwm_stop: assert property (s_measuring |-> (!ret_edge or (run_clr_o and s_pulse_end)))
        else $error("pulse end did not stop measurement");

endmodule

// ==== logic/tec_top.sv ====
// Timer/event counter block: three 8-bit channels and one 16-bit channel behind
// a byte-wide special function register port.
// Assumes all pins and strobes are synchronous to clk_i; the interrupt enable
// bits live in an interrupt controller outside and arrive on int_en_i.
//
// How it works
// - Count steps one per clock or pin edge.
// - All-ones overflow flags, interrupts, reloads, continues.
// - Preload write while off also loads count.
// - Preload write while running waits for overflow.
// - Wide low write goes to holding buffer.
// - Wide high write loads high plus buffer.
// - Wide high read latches low count.
// - Wide low read returns latched buffer.
// - Control bits seven and six pick mode.
// - Control bit four runs or stops.
// - Control bits two to zero set narrow prescale.
// - Event mode counts pin edges, no prescaler.
// - Edge select zero rising, one falling.
// - Narrow timers count prescaled system clock.
// - Wide timer uses sub clock or sys/4.
// - Overflow interrupt passes only when enabled.
// - Event counting continues in power-down, wakes.
// - Mode bits both set mean pulse measure.
// - Pulse measure counts while active, then stops.
`include "tec_consts.svh"

module tec_top (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [3:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic [3:0]  timer_pin_i,
    input  wire logic        sub_clock_i,
    input  wire logic        pdown_i,
    input  wire logic [3:0]  int_en_i,
    output logic      [3:0]  irq_o,
    output logic             wake_o
);

    localparam int NCH  = 4;
    localparam int WIDE = 1;

    typedef struct packed {
        logic [NCH-1:0][7:0]          ctrl;
        logic [7:0]                   low_buf;
        logic [`TEC_PSC_W-1:0]        presc;
        logic                         sub_q;
        logic [7:0]                   rdata;
    } tec_top_state_s;

    tec_top_state_s         q;
    tec_top_state_s         d;
    logic [NCH-1:0]         tick;
    logic [NCH-1:0]         load;
    logic [NCH-1:0][15:0]   load_data;
    logic [NCH-1:0][15:0]   count;
    logic [NCH-1:0]         ovf;
    logic [NCH-1:0]         run_clr;
    logic [NCH-1:0]         event_mode;

    // A prescaler ratio n gives a tick every 2**n system clocks.
    function automatic logic presc_tick(input logic [`TEC_PSC_W-1:0] cnt,
                                        input logic [2:0] sel);
        logic [7:0] m;
        m = (8'h01 << sel) - 8'h01;
        return ({1'b0, cnt} & m) == 8'h00;
    endfunction

    function automatic logic [1:0] mode_bits(input logic [7:0] c);
        return c[`TEC_MODE_HI:`TEC_MODE_LO];
    endfunction

    function automatic logic [7:0] ctrl_mask(input int ch);
        return (ch == WIDE) ? `TEC_CTRL_MASK_WIDE : `TEC_CTRL_MASK_NARROW;
    endfunction

    always_comb begin
        d         = q;
        d.presc   = q.presc + `TEC_PSC_W'(1);
        d.sub_q   = sub_clock_i;
        load      = '0;
        load_data = '0;
        for (int k = 0; k < NCH; k++) begin
            if (run_clr[k]) begin
                d.ctrl[k][`TEC_RUN_BIT] = 1'b0;
            end
        end
        for (int k = 0; k < NCH; k++) begin
            if (k == WIDE) begin
                // The wide channel has no prescaler; bit five picks its source.
                tick[k] = q.ctrl[k][`TEC_CLK_SEL_BIT] ? (sub_clock_i & ~q.sub_q)
                        : ((q.presc & `TEC_WIDE_DIV_MASK) == '0);
            end else begin
                tick[k] = presc_tick(q.presc, q.ctrl[k][`TEC_PSC_HI:0]);
            end
        end
        if (sfr_wr_i) begin
            // Software writes win over a same-cycle automatic run clear.
            if (sfr_addr_i == `TEC_ADDR_CNT_A) begin
                load[0]      = 1'b1;
                load_data[0] = {8'h00, sfr_wdata_i};
            end else if (sfr_addr_i == `TEC_ADDR_CTRL_A) begin
                d.ctrl[0] = sfr_wdata_i & ctrl_mask(0);
            end else if (sfr_addr_i == `TEC_ADDR_WIDE_LOW) begin
                d.low_buf = sfr_wdata_i;
            end else if (sfr_addr_i == `TEC_ADDR_WIDE_HIGH) begin
                load[WIDE]      = 1'b1;
                load_data[WIDE] = {sfr_wdata_i, q.low_buf};
            end else if (sfr_addr_i == `TEC_ADDR_CTRL_WIDE) begin
                d.ctrl[WIDE] = sfr_wdata_i & ctrl_mask(WIDE);
            end else if (sfr_addr_i == `TEC_ADDR_CNT_C) begin
                load[2]      = 1'b1;
                load_data[2] = {8'h00, sfr_wdata_i};
            end else if (sfr_addr_i == `TEC_ADDR_CTRL_C) begin
                d.ctrl[2] = sfr_wdata_i & ctrl_mask(2);
            end else if (sfr_addr_i == `TEC_ADDR_CNT_D) begin
                load[3]      = 1'b1;
                load_data[3] = {8'h00, sfr_wdata_i};
            end else if (sfr_addr_i == `TEC_ADDR_CTRL_D) begin
                d.ctrl[3] = sfr_wdata_i & ctrl_mask(3);
            end
        end else if (sfr_rd_i) begin
            if (sfr_addr_i == `TEC_ADDR_CNT_A) begin
                d.rdata = count[0][7:0];
            end else if (sfr_addr_i == `TEC_ADDR_CTRL_A) begin
                d.rdata = q.ctrl[0];
            end else if (sfr_addr_i == `TEC_ADDR_WIDE_LOW) begin
                d.rdata = q.low_buf;
            end else if (sfr_addr_i == `TEC_ADDR_WIDE_HIGH) begin
                d.rdata   = count[WIDE][15:8];
                d.low_buf = count[WIDE][7:0];
            end else if (sfr_addr_i == `TEC_ADDR_CTRL_WIDE) begin
                d.rdata = q.ctrl[WIDE];
            end else if (sfr_addr_i == `TEC_ADDR_CNT_C) begin
                d.rdata = count[2][7:0];
            end else if (sfr_addr_i == `TEC_ADDR_CTRL_C) begin
                d.rdata = q.ctrl[2];
            end else if (sfr_addr_i == `TEC_ADDR_CNT_D) begin
                d.rdata = count[3][7:0];
            end else if (sfr_addr_i == `TEC_ADDR_CTRL_D) begin
                d.rdata = q.ctrl[3];
            end else begin
                d.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    for (genvar k = 0; k < NCH; k++) begin : g_ch
        localparam int CW = (k == WIDE) ? 16 : 8;
        logic [CW-1:0] cnt_w;

        tec_counter #(
            .W (CW)
        ) u_cnt (
            .clk_i       (clk_i),
            .arst_n_i    (arst_n_i),
            .mode_i      (tec_pkg::tec_mode_e'(mode_bits(q.ctrl[k]))),
            .run_i       (q.ctrl[k][`TEC_RUN_BIT]),
            .edge_sel_i  (q.ctrl[k][`TEC_EDGE_BIT]),
            .tick_i      (tick[k]),
            .pdown_i     (pdown_i),
            .pin_i       (timer_pin_i[k]),
            .load_i      (load[k]),
            .load_data_i (load_data[k][CW-1:0]),
            .count_o     (cnt_w),
            .ovf_o       (ovf[k]),
            .run_clr_o   (run_clr[k])
        );

        assign count[k]      = 16'(cnt_w);
        assign event_mode[k] = mode_bits(q.ctrl[k]) == 2'b01;
    end

    assign irq_o       = ovf & int_en_i;
    assign wake_o      = pdown_i & |(irq_o & event_mode);
    assign sfr_rdata_o = q.rdata;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_wide_high_write;
        sfr_wr_i && sfr_addr_i == `TEC_ADDR_WIDE_HIGH && !q.ctrl[WIDE][`TEC_RUN_BIT];
    endsequence

    a_low_write_buf: assert property (sfr_wr_i && sfr_addr_i == `TEC_ADDR_WIDE_LOW |=> q.low_buf == $past(sfr_wdata_i))
        else $error("wide low write did not reach buffer");
    a_high_write_pair: assert property (s_wide_high_write |=> count[WIDE] == {$past(sfr_wdata_i), $past(q.low_buf)})
        else $error("wide high write did not load both bytes");
    a_high_read_latch: assert property (sfr_rd_i && !sfr_wr_i && sfr_addr_i == `TEC_ADDR_WIDE_HIGH |=> q.low_buf == $past(count[WIDE][7:0]))
        else $error("wide high read did not latch low byte");
    a_low_read_buf: assert property (sfr_rd_i && !sfr_wr_i && sfr_addr_i == `TEC_ADDR_WIDE_LOW |=> sfr_rdata_o == $past(q.low_buf))
        else $error("wide low read did not return buffer");
    a_irq_masked: assert property (ovf[0] |-> irq_o[0] == int_en_i[0])
        else $error("masked overflow raised interrupt");
    a_run_autoclr: assert property (run_clr[2] && !sfr_wr_i |=> !q.ctrl[2][`TEC_RUN_BIT] ##1 !run_clr[2])
        else $error("run enable not cleared after pulse");

endmodule

// ==== tb/tec_pin_model.sv ====
// Far-side model of the four timer pins and the sub clock source.
// Assumes the bench calls its tasks by hierarchy; every change follows a clk_i rise.
module tec_pin_model (
    input  wire logic       clk_i,
    output logic      [3:0] pin_o,
    output logic            sub_clock_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Channel C idles high so a falling edge can open a pulse measurement.
    initial begin
        pin_o = 4'h4;
        sub_clock_o = 1'b0;
    end

    // Each level is held for gap clocks so that every edge is sampled.
    task automatic toggle(input int ch, input int n, input int gap);
        repeat (n) begin
            @(posedge clk_i) pin_o[ch] <= ~pin_o[ch];
            repeat (gap - 1) @(posedge clk_i);
        end
    endtask

    task automatic subclk(input int n);
        repeat (2 * n) begin
            @(posedge clk_i) sub_clock_o <= ~sub_clock_o;
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule

// ==== tb/tb_tec_top.sv ====
// Self-checking bench for the timer/event counter block.
// Assumes tec_consts.svh on the include path and the pin model beside the design.
`include "tec_consts.svh"

module tb_tec_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [3:0] pin;
    logic       subc;
    logic       pdown = 1'b0;
    logic [3:0] int_en = 4'h0;
    logic [3:0] irq;
    logic       wake;
    logic [4:0] seen = 5'h00;
    logic [7:0] v;
    int         per;
    int         error_cnt = 0;
    int         n_checks = 0;
    int         cycles = 0;

    tec_top tec_top_i (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .sfr_addr_i  (addr),
        .sfr_wr_i    (wr),
        .sfr_rd_i    (rd),
        .sfr_wdata_i (wdata),
        .sfr_rdata_o (rdata),
        .timer_pin_i (pin),
        .sub_clock_i (subc),
        .pdown_i     (pdown),
        .int_en_i    (int_en),
        .irq_o       (irq),
        .wake_o      (wake)
    );

    tec_pin_model tec_pin_model_i (
        .clk_i       (clk_i),
        .pin_o       (pin),
        .sub_clock_o (subc)
    );

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Sticky catcher for one-cycle pulses, cleared by the scenarios.
    always @(negedge clk_i) begin
        seen <= seen | {wake, irq};
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        @(posedge clk_i);
        d = rdata;
    endtask

    // Waits for an interrupt of channel b, then counts clocks to the next one.
    // Two clocks pass first so that a pulse of the previous setting is not taken.
    task automatic irq_period(input int b, output int p);
        int c;
        c = 0;
        repeat (2) @(negedge clk_i);
        while (irq[b] !== 1'b1 && c < 600) begin
            @(negedge clk_i);
            c++;
        end
        p = 0;
        do begin
            @(negedge clk_i);
            p++;
        end while (irq[b] !== 1'b1 && p < 600);
    endtask

    task automatic t_reset_idle();
        rd_reg(`TEC_ADDR_CTRL_A, v);
        check("ctrl_a_reset", v, 8'h00);
        wr_reg(`TEC_ADDR_CNT_A, 8'h5a);
        rd_reg(`TEC_ADDR_CNT_A, v);
        check("cnt_a_load_off", v, 8'h5a);
        wr_reg(`TEC_ADDR_CTRL_A, 8'h10);
        repeat (20) @(posedge clk_i);
        rd_reg(`TEC_ADDR_CNT_A, v);
        check("cnt_a_idle_mode", v, 8'h5a);
        wr_reg(`TEC_ADDR_CTRL_A, 8'h00);
        $display("test reset_idle done");
    endtask

    task automatic t_prescale();
        wr_reg(`TEC_ADDR_CNT_A, 8'hff);
        int_en <= 4'h1;
        for (int n = 0; n < 8; n++) begin
            wr_reg(`TEC_ADDR_CTRL_A, 8'h90 | n[7:0]);
            irq_period(0, per);
            irq_period(0, per);
            check("irq_a_period", per[15:0], 16'h1 << n);
        end
        @(posedge clk_i) seen = 5'h00;
        int_en <= 4'h0;
        repeat (140) @(negedge clk_i);
        check("irq_a_masked", seen[0], 1'b0);
        wr_reg(`TEC_ADDR_CTRL_A, 8'h00);
        wr_reg(`TEC_ADDR_CNT_A, 8'hfd);
        int_en <= 4'h1;
        wr_reg(`TEC_ADDR_CTRL_A, 8'h97);
        wr_reg(`TEC_ADDR_CNT_A, 8'h20);
        rd_reg(`TEC_ADDR_CNT_A, v);
        check("cnt_a_held", v == 8'h20, 1'b0);
        while (irq[0] !== 1'b1) @(negedge clk_i);
        rd_reg(`TEC_ADDR_CNT_A, v);
        check("cnt_a_reload", v, 8'h20);
        wr_reg(`TEC_ADDR_CTRL_A, 8'h00);
        int_en <= 4'h0;
        $display("test prescale done");
    endtask

    task automatic t_event();
        wr_reg(`TEC_ADDR_CNT_A, 8'h00);
        wr_reg(`TEC_ADDR_CTRL_A, 8'h57);
        tec_pin_model_i.toggle(0, 5, 4);
        wr_reg(`TEC_ADDR_CTRL_A, 8'h00);
        rd_reg(`TEC_ADDR_CNT_A, v);
        check("cnt_a_rising", v, 8'h03);
        wr_reg(`TEC_ADDR_CNT_A, 8'h00);
        wr_reg(`TEC_ADDR_CTRL_A, 8'h5f);
        pdown <= 1'b1;
        tec_pin_model_i.toggle(0, 4, 4);
        wr_reg(`TEC_ADDR_CTRL_A, 8'h00);
        rd_reg(`TEC_ADDR_CNT_A, v);
        check("cnt_a_falling", v, 8'h02);
        wr_reg(`TEC_ADDR_CNT_A, 8'hff);
        int_en <= 4'h1;
        wr_reg(`TEC_ADDR_CTRL_A, 8'h58);
        @(posedge clk_i) seen = 5'h00;
        tec_pin_model_i.toggle(0, 1, 6);
        check("wake_event", seen[4], 1'b1);
        pdown <= 1'b0;
        int_en <= 4'h0;
        wr_reg(`TEC_ADDR_CTRL_A, 8'h00);
        $display("test event done");
    endtask

    task automatic t_wide();
        wr_reg(`TEC_ADDR_WIDE_LOW, 8'h34);
        rd_reg(`TEC_ADDR_WIDE_HIGH, v);
        rd_reg(`TEC_ADDR_WIDE_LOW, v);
        check("wide_low_untouched", v, 8'h00);
        wr_reg(`TEC_ADDR_WIDE_LOW, 8'h34);
        wr_reg(`TEC_ADDR_WIDE_HIGH, 8'h12);
        rd_reg(`TEC_ADDR_WIDE_HIGH, v);
        check("wide_high", v, 8'h12);
        rd_reg(`TEC_ADDR_WIDE_LOW, v);
        check("wide_low", v, 8'h34);
        wr_reg(`TEC_ADDR_WIDE_LOW, 8'h00);
        wr_reg(`TEC_ADDR_WIDE_HIGH, 8'h00);
        wr_reg(`TEC_ADDR_CTRL_WIDE, 8'h90);
        repeat (20) @(posedge clk_i);
        rd_reg(`TEC_ADDR_WIDE_HIGH, v);
        repeat (100) @(posedge clk_i);
        rd_reg(`TEC_ADDR_WIDE_LOW, v);
        check("wide_low_latched", v <= 8'h10, 1'b1);
        wr_reg(`TEC_ADDR_CTRL_WIDE, 8'h00);
        wr_reg(`TEC_ADDR_WIDE_LOW, 8'hff);
        wr_reg(`TEC_ADDR_WIDE_HIGH, 8'hff);
        int_en <= 4'h2;
        wr_reg(`TEC_ADDR_CTRL_WIDE, 8'h90);
        irq_period(1, per);
        irq_period(1, per);
        check("irq_wide_period", per[15:0], 16'h0004);
        wr_reg(`TEC_ADDR_CTRL_WIDE, 8'h00);
        wr_reg(`TEC_ADDR_WIDE_LOW, 8'h00);
        wr_reg(`TEC_ADDR_WIDE_HIGH, 8'h00);
        wr_reg(`TEC_ADDR_CTRL_WIDE, 8'hb0);
        tec_pin_model_i.subclk(6);
        wr_reg(`TEC_ADDR_CTRL_WIDE, 8'h00);
        repeat (10) @(posedge clk_i);
        rd_reg(`TEC_ADDR_WIDE_HIGH, v);
        rd_reg(`TEC_ADDR_WIDE_LOW, v);
        check("wide_sub_count", v, 8'h06);
        int_en <= 4'h0;
        $display("test wide done");
    endtask

    task automatic t_pulse();
        logic [7:0] w;
        wr_reg(`TEC_ADDR_CNT_C, 8'h00);
        wr_reg(`TEC_ADDR_CTRL_C, 8'hd0);
        tec_pin_model_i.toggle(2, 2, 20);
        repeat (4) @(posedge clk_i);
        rd_reg(`TEC_ADDR_CTRL_C, v);
        check("ctrl_c_run_cleared", v, 8'hc0);
        rd_reg(`TEC_ADDR_CNT_C, v);
        check("cnt_c_width", v >= 8'h13 && v <= 8'h15, 1'b1);
        tec_pin_model_i.toggle(2, 2, 20);
        rd_reg(`TEC_ADDR_CNT_C, w);
        check("cnt_c_ignored", w, v);
        wr_reg(`TEC_ADDR_CNT_D, 8'h00);
        wr_reg(`TEC_ADDR_CTRL_D, 8'hd8);
        tec_pin_model_i.toggle(3, 2, 10);
        rd_reg(`TEC_ADDR_CTRL_D, v);
        check("ctrl_d_run_cleared", v, 8'hc8);
        rd_reg(`TEC_ADDR_CNT_D, v);
        check("cnt_d_width", v >= 8'h08 && v <= 8'h0a, 1'b1);
        $display("test pulse done");
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_reset_idle();
        t_prescale();
        t_event();
        t_wide();
        t_pulse();
        test_done();
    end
endmodule
